// file: hdl/mrrc_core.sv
// command executor: routing port set, response kill, default routes, access tone, macro runner
// assumes decoded commands from the front ends and raw dtmf digit-present pins per radio port
`timescale 1ns/1ps
module mrrc_core #(
	parameter int TONE_UNIT_CYCLES = mrrc_pkg::TONE_UNIT_CYCLES
) (
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        cmd_valid_in,
	output logic                             cmd_ready_out,
	input  wire mrrc_pkg::mrrc_op_type       cmd_op_in,
	input  wire mrrc_pkg::mrrc_src_type      cmd_src_in,
	input  wire logic [mrrc_pkg::PORT_W-1:0] cmd_port_in,
	input  wire logic [1:0]                  cmd_sel_in,
	input  wire logic [mrrc_pkg::ROUTE_W-1:0] cmd_arg_in,
	input  wire logic                        mac_wr_en_in,
	input  wire logic [mrrc_pkg::MAC_AW-1:0] mac_wr_addr_in,
	input  wire logic [mrrc_pkg::MAC_DW-1:0] mac_wr_data_in,
	input  wire logic [mrrc_pkg::NPORT-1:0]  dtmf_digit_in,
	output logic                             resp_valid_out,
	output mrrc_pkg::mrrc_resp_type          resp_kind_out,
	output logic [mrrc_pkg::ROUTE_W-1:0]     resp_route_out,
	output logic [mrrc_pkg::ROUTE_W-1:0]     resp_ports_out,
	output logic [1:0]                       resp_sel_out,
	output logic                             resp_direct_out,
	output logic [mrrc_pkg::PORT_W-1:0]      resp_from_port_out,
	output logic                             tone_on_out,
	output logic [mrrc_pkg::PORT_W-1:0]      tone_port_out,
	output logic [mrrc_pkg::ROUTE_W-1:0]     route_port_set_out,
	output logic                             macro_busy_out
);
	typedef enum {ST_IDLE, ST_READ, ST_EXEC} mrrc_state_type;

	mrrc_state_type                 state;
	logic [mrrc_pkg::MAC_AW-1:0]    pc;
	logic [mrrc_pkg::MAC_DW-1:0]    mem_q;
	logic [mrrc_pkg::ROUTE_W-1:0]   audio_route_port_set;
	logic [mrrc_pkg::ROUTE_W-1:0]   saved_route;
	logic [mrrc_pkg::ROUTE_W-1:0]   def_route [3];
	logic                           kill;
	logic [mrrc_pkg::PORT_W-1:0]    macro_port;
	logic [mrrc_pkg::NPORT-1:0]     dtmf_s1;
	logic [mrrc_pkg::NPORT-1:0]     dtmf_s2;
	logic [7:0]                     tone_len;
	logic [7:0]                     len_left;
	logic [mrrc_pkg::UNIT_CNT_W-1:0] unit_cnt;
	logic                           unit_wrap;
	logic                           tone_expire;
	logic                           tone_digit;

	logic                           ex_fire;
	logic                           ex_macro;
	logic                           ex_last;
	mrrc_pkg::mrrc_op_type          ex_op;
	logic [1:0]                     ex_sel;
	logic [mrrc_pkg::ROUTE_W-1:0]   ex_arg;
	logic [mrrc_pkg::PORT_W-1:0]    ex_port;
	logic [mrrc_pkg::ROUTE_W-1:0]   src_route;
	logic [mrrc_pkg::ROUTE_W-1:0]   cur_route;
	logic                           ex_killed;
	logic                           want_resp;
	mrrc_pkg::mrrc_resp_type        next_kind;
	logic [mrrc_pkg::ROUTE_W-1:0]   next_ports;

	mrrc_macro_mem u_mem (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.wr_en_in    (mac_wr_en_in),
		.wr_addr_in  (mac_wr_addr_in),
		.wr_data_in  (mac_wr_data_in),
		.rd_addr_in  (pc),
		.rd_data_out (mem_q)
	);

	assign cmd_ready_out      = (state == ST_IDLE);
	assign macro_busy_out     = (state != ST_IDLE);
	assign route_port_set_out = audio_route_port_set;

	// one execution slot shared by direct commands and macro steps
	always_comb begin
		ex_macro = (state == ST_EXEC);
		ex_fire  = ex_macro || (cmd_valid_in && state == ST_IDLE);
		ex_op    = ex_macro ? mrrc_pkg::mrrc_op_type'(mem_q[mrrc_pkg::MAC_OP_LSB +: 4]) : cmd_op_in;
		ex_sel   = ex_macro ? mem_q[mrrc_pkg::MAC_SEL_LSB +: 2] : cmd_sel_in;
		ex_arg   = ex_macro ? mem_q[mrrc_pkg::MAC_ARG_LSB +: mrrc_pkg::ROUTE_W] : cmd_arg_in;
		ex_port  = ex_macro ? macro_port : cmd_port_in;
		// a missing end mark cannot run the step pointer past the store
		ex_last  = ex_macro && (mem_q[mrrc_pkg::MAC_LAST_BIT] || pc == mrrc_pkg::PC_LAST);
		ex_killed = ex_macro && kill;
	end

	always_comb begin
		case (cmd_src_in)
			mrrc_pkg::SRC_DTMF:   src_route = mrrc_pkg::ROUTE_W'(8'h01 << cmd_port_in);
			mrrc_pkg::SRC_SERIAL: src_route = def_route[0];
			mrrc_pkg::SRC_SCHED:  src_route = def_route[1];
			default:              src_route = def_route[2];
		endcase
		cur_route = ex_macro ? audio_route_port_set : src_route;
	end

	always_comb begin
		want_resp  = 1'b0;
		next_kind  = mrrc_pkg::RESP_NORMAL;
		next_ports = '0;
		case (ex_op)
			mrrc_pkg::OP_GENERIC, mrrc_pkg::OP_TONE_TIMER: begin
				want_resp = 1'b1;
			end
			mrrc_pkg::OP_ROUTE_RECALL: begin
				want_resp  = 1'b1;
				next_kind  = mrrc_pkg::RESP_ROUTE;
				next_ports = cur_route;
			end
			mrrc_pkg::OP_DEFAULT_ROUTE_SET: begin
				want_resp  = (ex_sel <= mrrc_pkg::SEL_AUTO);
				next_kind  = mrrc_pkg::RESP_DEFAULT;
				next_ports = ex_arg;
			end
			mrrc_pkg::OP_DEFAULT_ROUTE_RECALL: begin
				want_resp  = (ex_sel <= mrrc_pkg::SEL_RESETM);
				next_kind  = mrrc_pkg::RESP_DEFAULT;
				next_ports = (ex_sel <= mrrc_pkg::SEL_RESETM) ? def_route[ex_sel] : '0;
			end
			default: begin
				want_resp = 1'b0;
			end
		endcase
	end

	// RULE14 ordered macro steps
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
			pc    <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (cmd_valid_in && cmd_op_in == mrrc_pkg::OP_MACRO_RUN) begin
						pc    <= cmd_arg_in[mrrc_pkg::MAC_AW-1:0];
						state <= ST_READ;
					end
				end
				ST_READ: begin
					state <= ST_EXEC;
				end
				ST_EXEC: begin
					if (ex_last) begin
						state <= ST_IDLE;
					end else begin
						pc    <= pc + 4'h1;
						state <= ST_READ;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			macro_port <= '0;
		end else if (ex_fire && !ex_macro && ex_op == mrrc_pkg::OP_MACRO_RUN) begin
			macro_port <= cmd_port_in;
		end
	end

	// RULE3 macro changes stand until the end
	// RULE4 end of macro restores the saved set
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			audio_route_port_set <= mrrc_pkg::ROUTE_RST;
			saved_route          <= mrrc_pkg::ROUTE_RST;
		end else if (ex_fire) begin
			if (ex_macro) begin
				if (ex_last) begin
					audio_route_port_set <= saved_route;
				end else if (ex_op == mrrc_pkg::OP_ROUTE_SET) begin
					audio_route_port_set <= ex_arg;
				end
			end else if (ex_op == mrrc_pkg::OP_ROUTE_SET) begin
				audio_route_port_set <= ex_arg;
			end else begin
				// macro steps start on the source route; the older set is kept for the end
				saved_route          <= audio_route_port_set;
				audio_route_port_set <= src_route;
				if (ex_op != mrrc_pkg::OP_MACRO_RUN) begin
					saved_route <= saved_route;
				end
			end
		end
	end

	// RULE1 kill holds for the rest of the macro
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			kill <= 1'b0;
		end else if (ex_fire && ex_macro) begin
			kill <= !ex_last && (kill || ex_op == mrrc_pkg::OP_RESPONSE_KILL);
		end else if (ex_fire) begin
			kill <= 1'b0;
		end
	end

	// RULE7 RULE8 RULE9 default route programming
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			def_route[0] <= mrrc_pkg::DEF_SERIAL_RST;
			def_route[1] <= mrrc_pkg::DEF_SCHED_RST;
			def_route[2] <= mrrc_pkg::DEF_RESETM_RST;
		end else if (ex_fire && ex_op == mrrc_pkg::OP_DEFAULT_ROUTE_SET
			&& ex_sel <= mrrc_pkg::SEL_AUTO) begin
			def_route[ex_sel] <= ex_arg;
		end
	end

	// RULE2 RULE5 RULE6 RULE10 RULE11 response strobe
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			resp_valid_out     <= 1'b0;
			resp_kind_out      <= mrrc_pkg::RESP_NORMAL;
			resp_route_out     <= '0;
			resp_ports_out     <= '0;
			resp_sel_out       <= '0;
			resp_direct_out    <= 1'b0;
			resp_from_port_out <= '0;
		end else begin
			resp_valid_out <= ex_fire && want_resp && !ex_killed;
			if (ex_fire && want_resp && !ex_killed) begin
				resp_kind_out      <= next_kind;
				resp_route_out     <= cur_route;
				resp_ports_out     <= next_ports;
				resp_sel_out       <= ex_sel;
				resp_direct_out    <= !ex_macro;
				resp_from_port_out <= ex_port;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			dtmf_s1 <= '0;
			dtmf_s2 <= '0;
		end else begin
			dtmf_s1 <= dtmf_digit_in;
			dtmf_s2 <= dtmf_s1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			tone_len <= mrrc_pkg::TONE_LEN_RST;
		end else if (ex_fire && ex_op == mrrc_pkg::OP_TONE_TIMER) begin
			tone_len <= ex_arg;
		end
	end

	assign unit_wrap   = (unit_cnt == mrrc_pkg::UNIT_CNT_W'(TONE_UNIT_CYCLES - 1));
	assign tone_expire = tone_on_out && unit_wrap && len_left <= 8'h01;
	assign tone_digit  = tone_on_out && dtmf_s2[tone_port_out];

	// RULE12 tone on requesting port only
	// RULE13 digit or timer ends the tone
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			tone_on_out   <= 1'b0;
			tone_port_out <= '0;
			unit_cnt      <= '0;
			len_left      <= '0;
		end else if (ex_fire && ex_op == mrrc_pkg::OP_TONE_START) begin
			tone_on_out   <= 1'b1;
			tone_port_out <= ex_port;
			unit_cnt      <= '0;
			len_left      <= tone_len;
		end else if (tone_expire || tone_digit) begin
			tone_on_out <= 1'b0;
		end else if (tone_on_out) begin
			unit_cnt <= unit_wrap ? '0 : unit_cnt + 1'b1;
			if (unit_wrap) begin
				len_left <= len_left - 8'h01;
			end
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	chk_kill_silent: assert property (ex_fire && ex_killed |=> !resp_valid_out) // RULE1
		else $error("response escaped a killed macro");
	chk_normal_resp: assert property (ex_fire && ex_op == mrrc_pkg::OP_GENERIC && !ex_killed
		|=> resp_valid_out && resp_kind_out == mrrc_pkg::RESP_NORMAL) // RULE2
		else $error("normal response missing");
	chk_route_hold: assert property (ex_macro && !ex_last && ex_op != mrrc_pkg::OP_ROUTE_SET
		|=> $stable(audio_route_port_set)) // RULE3
		else $error("route changed inside macro");
	chk_route_restore: assert property (ex_fire && ex_last
		|=> audio_route_port_set == $past(saved_route)) // RULE4
		else $error("route not restored at macro end");
	chk_recall_ports: assert property (ex_fire && ex_op == mrrc_pkg::OP_ROUTE_RECALL && !ex_killed
		|=> resp_ports_out == $past(cur_route) && resp_kind_out == mrrc_pkg::RESP_ROUTE) // RULE5
		else $error("route recall wrong ports");
	chk_direct_port: assert property (ex_fire && !ex_macro && ex_op == mrrc_pkg::OP_ROUTE_RECALL
		|=> resp_direct_out && resp_from_port_out == $past(cmd_port_in)) // RULE6
		else $error("direct recall lost port");
	chk_default_set: assert property (ex_fire && ex_op == mrrc_pkg::OP_DEFAULT_ROUTE_SET
		&& ex_sel == mrrc_pkg::SEL_SERIAL |=> def_route[0] == $past(ex_arg)) // RULE9
		else $error("default route not written");
	chk_default_answer: assert property (ex_fire && !ex_killed
		&& ex_op == mrrc_pkg::OP_DEFAULT_ROUTE_RECALL && ex_sel <= mrrc_pkg::SEL_RESETM
		|=> resp_valid_out && resp_sel_out == $past(ex_sel)
		&& resp_kind_out == mrrc_pkg::RESP_DEFAULT) // RULE11
		else $error("default answer malformed");
	chk_tone_port: assert property (ex_fire && ex_op == mrrc_pkg::OP_TONE_START
		|=> tone_on_out && tone_port_out == $past(ex_port) && !resp_valid_out) // RULE12
		else $error("tone start misrouted");
	chk_tone_digit: assert property (tone_digit && !(ex_fire && ex_op == mrrc_pkg::OP_TONE_START)
		|=> !tone_on_out) // RULE13
		else $error("tone ignored a digit");
	chk_macro_order: assert property (ex_macro && !ex_last
		|=> state == ST_READ ##1 state == ST_EXEC && pc == $past(pc, 2) + 4'h1) // RULE14
		else $error("macro step out of order");

	cov_killed_macro: cover property (ex_fire && ex_killed && want_resp);
	cov_restore: cover property (ex_last && audio_route_port_set != saved_route);
	cov_tone_digit: cover property (tone_digit);
	cov_default_recall: cover property (ex_fire && ex_op == mrrc_pkg::OP_DEFAULT_ROUTE_RECALL);
endmodule

// file: hdl/mrrc_macro_mem.sv
// macro command store: one stored command per word, registered read
// assumes the loader writes whole words; read data lag the address by one clock
`timescale 1ns/1ps
module mrrc_macro_mem (
	input  wire logic                       clk_sys_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       wr_en_in,
	input  wire logic [mrrc_pkg::MAC_AW-1:0] wr_addr_in,
	input  wire logic [mrrc_pkg::MAC_DW-1:0] wr_data_in,
	input  wire logic [mrrc_pkg::MAC_AW-1:0] rd_addr_in,
	output logic      [mrrc_pkg::MAC_DW-1:0] rd_data_out
);
	logic [mrrc_pkg::MAC_DW-1:0] store [2**mrrc_pkg::MAC_AW];

	always_ff @(posedge clk_sys_in) begin
		if (wr_en_in) begin
			store[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rd_data_out <= '0;
		end else begin
			rd_data_out <= store[rd_addr_in];
		end
	end
endmodule

// file: hdl/mrrc_pkg.sv
// constants, field layout and enumerations for the macro response and routing control block
// assumes one 40 MHz clock; commands arrive already decoded from dtmf or serial front ends
// Notes on behaviour
// RULE1 - kill silences later responses inside macro
// RULE2 - without kill, macro commands answer normally
// RULE3 - macro changes stand until macro ends
// RULE4 - macro end restores previous routing port set
// RULE5 - route recall reports current routing ports
// RULE6 - direct route recall reports requesting port
// RULE7 - default set chooses ports for a source
// RULE8 - default set selector: 0 serial, 1 auto
// RULE9 - no port digits means route nowhere
// RULE10 - default recall selector: serial, scheduler, reset macro
// RULE11 - default answers give selector, IS, ports
// RULE12 - tone goes only to requesting port, silently
// RULE13 - tone stops on port digit or timer
// RULE14 - macro commands run in stored order
package mrrc_pkg;
	localparam int CLK_HZ           = 40_000_000;
	localparam int TONE_UNIT_MS     = 100;
	localparam int TONE_UNIT_CYCLES = CLK_HZ / 1000 * TONE_UNIT_MS;
	localparam int UNIT_CNT_W       = 22;
	localparam int ROUTE_W          = 8;
	localparam int PORT_W           = 2;
	localparam int NPORT            = 4;
	localparam int MAC_AW           = 4;
	localparam int MAC_DW           = 15;
	localparam int MAC_LAST_BIT     = 14;
	localparam int MAC_OP_LSB       = 10;
	localparam int MAC_SEL_LSB      = 8;
	localparam int MAC_ARG_LSB      = 0;
	localparam logic [ROUTE_W-1:0] ROUTE_RST     = 8'h00;
	localparam logic [ROUTE_W-1:0] DEF_SERIAL_RST = 8'h01;
	localparam logic [ROUTE_W-1:0] DEF_SCHED_RST  = 8'h01;
	localparam logic [ROUTE_W-1:0] DEF_RESETM_RST = 8'h01;
	localparam logic [7:0]         TONE_LEN_RST  = 8'h0A;
	localparam logic [1:0]         SEL_SERIAL    = 2'h0;
	localparam logic [1:0]         SEL_AUTO      = 2'h1;
	localparam logic [1:0]         SEL_RESETM    = 2'h2;
	localparam logic [MAC_AW-1:0]  PC_LAST       = 4'hF;

	typedef enum logic [3:0] {
		OP_GENERIC,
		OP_ROUTE_SET,
		OP_RESPONSE_KILL,
		OP_ROUTE_RECALL,
		OP_DEFAULT_ROUTE_SET,
		OP_DEFAULT_ROUTE_RECALL,
		OP_TONE_START,
		OP_TONE_TIMER,
		OP_MACRO_RUN
	} mrrc_op_type;

	typedef enum logic [1:0] {
		SRC_DTMF,
		SRC_SERIAL,
		SRC_SCHED,
		SRC_RESETM
	} mrrc_src_type;

	typedef enum logic [1:0] {
		RESP_NORMAL,
		RESP_ROUTE,
		RESP_DEFAULT
	} mrrc_resp_type;
endpackage

// file: test/mrrc_core_bench.sv
// self-checking bench for the command executor: a table of direct commands,
// then macro, tone and reset cases by hand
// assumes mrrc_pkg, mrrc_core and mrrc_user_model are compiled before it
`timescale 1ns/1ps
module mrrc_core_bench;
	typedef struct packed {
		logic [3:0] op;
		logic [1:0] src;
		logic [1:0] port;
		logic [1:0] sel;
		logic [7:0] arg;
		logic       v;
		logic [1:0] kind;
		logic [7:0] route;
		logic [7:0] ports;
	} mrrc_row_type;
	localparam mrrc_row_type ROWS [14] = '{
		'{4'h0, 2'h0, 2'h2, 2'h0, 8'h00, 1'h1, 2'h0, 8'h04, 8'h00},
		'{4'h4, 2'h1, 2'h0, 2'h0, 8'h06, 1'h1, 2'h2, 8'h00, 8'h06},
		'{4'h5, 2'h1, 2'h0, 2'h0, 8'h00, 1'h1, 2'h2, 8'h00, 8'h06},
		'{4'h4, 2'h1, 2'h0, 2'h1, 8'h00, 1'h1, 2'h2, 8'h00, 8'h00},
		'{4'h5, 2'h1, 2'h0, 2'h1, 8'h00, 1'h1, 2'h2, 8'h00, 8'h00},
		'{4'h5, 2'h1, 2'h0, 2'h2, 8'h00, 1'h1, 2'h2, 8'h00, 8'h01},
		'{4'h4, 2'h1, 2'h0, 2'h2, 8'h05, 1'h0, 2'h0, 8'h00, 8'h00},
		'{4'h5, 2'h1, 2'h0, 2'h3, 8'h00, 1'h0, 2'h0, 8'h00, 8'h00},
		'{4'h0, 2'h1, 2'h0, 2'h0, 8'h00, 1'h1, 2'h0, 8'h06, 8'h00},
		'{4'h0, 2'h2, 2'h0, 2'h0, 8'h00, 1'h1, 2'h0, 8'h00, 8'h00},
		'{4'h0, 2'h3, 2'h0, 2'h0, 8'h00, 1'h1, 2'h0, 8'h01, 8'h00},
		'{4'h3, 2'h0, 2'h3, 2'h0, 8'h00, 1'h1, 2'h1, 8'h00, 8'h08},
		'{4'h2, 2'h0, 2'h0, 2'h0, 8'h00, 1'h0, 2'h0, 8'h00, 8'h00},
		'{4'h1, 2'h0, 2'h0, 2'h0, 8'h0F, 1'h0, 2'h0, 8'h00, 8'h00}};
	// macro: recall, route 0x30, generic, kill, generic, recall (last)
	localparam logic [14:0] MAC [6] = '{15'h0C00, 15'h0430, 15'h0000,
		15'h0800, 15'h0000, 15'h4C00};
	logic                    clk_sys_in = 1'b0;
	logic                    rst_n_in = 1'b0;
	logic                    cmd_valid_in = 1'b0;
	mrrc_pkg::mrrc_op_type   cmd_op_in = mrrc_pkg::OP_GENERIC;
	mrrc_pkg::mrrc_src_type  cmd_src_in = mrrc_pkg::SRC_DTMF;
	logic [1:0]              cmd_port_in = 2'h0;
	logic [1:0]              cmd_sel_in = 2'h0;
	logic [7:0]              cmd_arg_in = 8'h00;
	logic                    mac_wr_en_in = 1'b0;
	logic [3:0]              mac_wr_addr_in = 4'h0;
	logic [14:0]             mac_wr_data_in = 15'h0000;
	logic                    press_in = 1'b0;
	logic [1:0]              press_port_in = 2'h0;
	logic [3:0]              dtmf_digit_in;
	logic                    cmd_ready_out;
	logic                    resp_valid_out;
	mrrc_pkg::mrrc_resp_type resp_kind_out;
	logic [7:0]              resp_route_out;
	logic [7:0]              resp_ports_out;
	logic [1:0]              resp_sel_out;
	logic                    resp_direct_out;
	logic [1:0]              resp_from_port_out;
	logic                    tone_on_out;
	logic [1:0]              tone_port_out;
	logic [7:0]              route_port_set_out;
	logic                    macro_busy_out;
	logic [17:0]             resp_q [$];
	int                      err_total = 0;
	int                      samples_checked = 0;
	int                      n;
	mrrc_row_type            r;

	always #12.5 clk_sys_in = ~clk_sys_in;

	mrrc_core #(.TONE_UNIT_CYCLES(4)) mrrc_core_inst (.clk_sys_in, .rst_n_in, .cmd_valid_in,
		.cmd_ready_out, .cmd_op_in, .cmd_src_in, .cmd_port_in, .cmd_sel_in, .cmd_arg_in,
		.mac_wr_en_in, .mac_wr_addr_in, .mac_wr_data_in, .dtmf_digit_in, .resp_valid_out,
		.resp_kind_out, .resp_route_out, .resp_ports_out, .resp_sel_out, .resp_direct_out,
		.resp_from_port_out, .tone_on_out, .tone_port_out, .route_port_set_out,
		.macro_busy_out);
	mrrc_user_model mrrc_user_model_inst (.clk_sys_in, .press_in, .press_port_in,
		.dtmf_digit_out(dtmf_digit_in));

	// every response pulse is logged as kind, route, reported ports
	// sampled mid-cycle so the registered pulse is settled when it is read
	always @(negedge clk_sys_in) begin
		if (resp_valid_out === 1'b1)
			resp_q.push_back({resp_kind_out, resp_route_out, resp_ports_out});
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// fields are held until the take edge; ends at the negedge after it
	task automatic send(input logic [3:0] op, input logic [1:0] src, input logic [1:0] port,
		input logic [1:0] sel, input logic [7:0] arg);
		@(posedge clk_sys_in);
		cmd_valid_in <= 1'b1;
		cmd_op_in <= mrrc_pkg::mrrc_op_type'(op);
		cmd_src_in <= mrrc_pkg::mrrc_src_type'(src);
		cmd_port_in <= port;
		cmd_sel_in <= sel;
		cmd_arg_in <= arg;
		@(posedge clk_sys_in);
		while (cmd_ready_out !== 1'b1)
			@(posedge clk_sys_in);
		cmd_valid_in <= 1'b0;
		@(negedge clk_sys_in);
	endtask

	task automatic key(input logic [1:0] port);
		@(posedge clk_sys_in);
		press_in <= 1'b1;
		press_port_in <= port;
		@(posedge clk_sys_in);
		press_in <= 1'b0;
	endtask

	task automatic conclude();
		$display("checked %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#50000;
		err_total++;
		conclude();
	end

	initial begin
		repeat (3) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		foreach (ROWS[i]) begin
			r = ROWS[i];
			send(r.op, r.src, r.port, r.sel, r.arg);
			chk("resp_valid", resp_valid_out, r.v);
			if (r.v && r.kind == 2'h0)
				chk("resp_route", resp_route_out, r.route);
			if (r.v && r.kind != 2'h0) begin
				chk("resp_kind", resp_kind_out, r.kind);
				chk("resp_ports", resp_ports_out, r.ports);
			end
			if (r.v && r.kind == 2'h2)
				chk("resp_sel", resp_sel_out, r.sel);
			if (r.v && r.kind == 2'h1)
				chk("from_port", {resp_direct_out, resp_from_port_out}, 3'h7);
		end
		foreach (MAC[i]) begin
			@(posedge clk_sys_in);
			mac_wr_en_in <= 1'b1;
			mac_wr_addr_in <= 4'(i);
			mac_wr_data_in <= MAC[i];
		end
		@(posedge clk_sys_in);
		mac_wr_en_in <= 1'b0;
		resp_q.delete();
		chk("route before", route_port_set_out, 8'h0F);
		send(4'h8, 2'h0, 2'h1, 2'h0, 8'h00);
		chk("ready in macro", cmd_ready_out, 1'b0);
		for (n = 0; n < 60 && macro_busy_out !== 1'b0; n++)
			@(negedge clk_sys_in);
		chk("macro busy", macro_busy_out, 1'b0);
		chk("route after", route_port_set_out, 8'h0F);
		chk("macro from", {resp_direct_out, resp_from_port_out}, 3'h1);
		chk("macro resp count", 16'(resp_q.size()), 16'h2);
		if (resp_q.size() == 2) begin
			chk("step recall", {resp_q[0][17:16], resp_q[0][7:0]}, 10'h102);
			chk("step generic", resp_q[1][17:8], 10'h030);
		end
		send(4'h7, 2'h0, 2'h0, 2'h0, 8'h02);
		send(4'h6, 2'h0, 2'h1, 2'h0, 8'h00);
		chk("tone silent", resp_valid_out, 1'b0);
		chk("tone port", {tone_on_out, tone_port_out}, 3'h5);
		for (n = 0; n < 100 && tone_on_out === 1'b1; n++)
			@(negedge clk_sys_in);
		chk("tone length", n[15:0], 16'h0008);
		send(4'h7, 2'h0, 2'h0, 2'h0, 8'h0A);
		send(4'h6, 2'h0, 2'h2, 2'h0, 8'h00);
		key(2'h0);
		repeat (6) @(negedge clk_sys_in);
		chk("tone other key", tone_on_out, 1'b1);
		key(2'h2);
		repeat (5) @(negedge clk_sys_in);
		chk("tone key stop", tone_on_out, 1'b0);
		send(4'h6, 2'h0, 2'h3, 2'h0, 8'h00);
		@(posedge clk_sys_in);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk("reset outs", {cmd_ready_out, resp_valid_out, tone_on_out, macro_busy_out}, 4'h8);
		chk("reset route", route_port_set_out, 8'h00);
		@(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		send(4'h5, 2'h1, 2'h0, 2'h0, 8'h00);
		chk("default reset", resp_ports_out, 8'h01);
		conclude();
	end
endmodule

// file: test/mrrc_user_model.sv
// far-side user model: keys a dtmf digit-present level on one radio port
// assumes the bench pulses press_in for one clock to start a key-down
`timescale 1ns/1ps
module mrrc_user_model #(
	parameter int HOLD_CYCLES = 4
) (
	input  wire logic       clk_sys_in,
	input  wire logic       press_in,
	input  wire logic [1:0] press_port_in,
	output logic      [3:0] dtmf_digit_out
);
	int         left = 0;
	logic [1:0] port = 2'h0;
	// a key is held several clocks so the two-stage sync cannot miss it
	always @(posedge clk_sys_in) begin
		if (press_in) begin
			left <= HOLD_CYCLES;
			port <= press_port_in;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end
	assign dtmf_digit_out = (left > 0) ? (4'h1 << port) : 4'h0;
endmodule
